// ==== rtl/fund_accum_pkg.sv ====
// Constants shared by the fundamental energy accumulator block.
// Assumes a 10-bit register address space of the metering front-end.
package fund_accum_pkg;

    // Structure
    localparam int NUM_PHASES = 3;
    localparam int ACC_W = 32;
    localparam int ADDR_W = 10;
    localparam int FLAG_W = 8;
    localparam int RD_W = 32;

    // Clock
    localparam int CLK_FREQ_HZ = 20_000_000;

    // Accumulator register addresses, index 0..2 is phase A..C
    localparam logic [ADDR_W-1:0] RNEG_ADDR [NUM_PHASES] =
        '{10'h208, 10'h2F4, 10'h3F0};
    localparam logic [ADDR_W-1:0] APP_ADDR [NUM_PHASES] =
        '{10'h20C, 10'h2F8, 10'h3E4};

    // Overflow flag register addresses, one per phase
    localparam logic [ADDR_W-1:0] FLAG_ADDR [NUM_PHASES] =
        '{10'h147, 10'h233, 10'h31F};

    // Flag bit positions
    localparam int RNEG_OVF_BIT = 3;
    localparam int APP_OVF_BIT = 4;

    // Reset values
    localparam logic [31:0] ACCUM_RESET = 32'h0000_0000;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [RD_W-1:0] RD_IDLE = 32'h0000_0000;

endpackage : fund_accum_pkg

// ==== rtl/accum_if.sv ====
// Per-phase link between the accumulator top and one phase slice.
// Assumes the top drives the cycle inputs and the slice returns sums.
`timescale 1ns/1ns
interface accum_if #(parameter int W = 32);
    logic strobe;
    logic low_power;
    logic [W-1:0] react;
    logic [W-1:0] app;
    logic [W-1:0] current;
    logic [W-1:0] rneg_acc;
    logic [W-1:0] app_acc;
    logic rneg_wrap;
    logic app_wrap;

    modport top (
        output strobe, low_power, react, app, current,
        input rneg_acc, app_acc, rneg_wrap, app_wrap
    );
    modport phase (
        input strobe, low_power, react, app, current,
        output rneg_acc, app_acc, rneg_wrap, app_wrap
    );
endinterface : accum_if

// ==== rtl/phase_accum.sv ====
// One phase of fundamental reactive-negative and apparent accumulation.
// Assumes a one-cycle end-of-cycle strobe and synchronous inputs.
`timescale 1ns/1ns
module phase_accum
    import fund_accum_pkg::*;
#(
    parameter int W = ACC_W
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Link to the top
    accum_if.phase bus
);

    logic [W-1:0] rneg;
    logic [W-1:0] app;
    logic rneg_wrap;
    logic app_wrap;
    logic [W-1:0] next_rneg;
    logic [W-1:0] next_app;
    logic next_rneg_wrap;
    logic next_app_wrap;
    logic [W-1:0] mag;
    logic [W-1:0] addend;
    logic [W:0] rneg_sum;
    logic [W:0] app_sum;

    // Sums are one bit wider; the top bit is the wrap carry
    always_comb begin
        mag = W'(~bus.react + 1'b1);
        addend = bus.low_power ? bus.current : bus.app;
        rneg_sum = {1'b0, rneg} + {1'b0, mag};
        app_sum = {1'b0, app} + {1'b0, addend};
        next_rneg = rneg;
        next_app = app;
        next_rneg_wrap = 1'b0;
        next_app_wrap = 1'b0;
        if (bus.strobe) begin
            // Only a negative cycle value feeds this sum
            if (bus.react[W-1]) begin
                next_rneg = rneg_sum[W-1:0];
                next_rneg_wrap = rneg_sum[W];
            end
            // No sign test: apparent or current magnitude added
            next_app = app_sum[W-1:0];
            next_app_wrap = app_sum[W];
        end
    end

    // Register stage, frozen while the clock enable is low
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rneg <= W'(ACCUM_RESET);
            app <= W'(ACCUM_RESET);
            rneg_wrap <= 1'b0;
            app_wrap <= 1'b0;
        end else if (i_ce) begin
            rneg <= next_rneg;
            app <= next_app;
            rneg_wrap <= next_rneg_wrap;
            app_wrap <= next_app_wrap;
        end
    end

    assign bus.rneg_acc = rneg;
    assign bus.app_acc = app;
    assign bus.rneg_wrap = rneg_wrap;
    assign bus.app_wrap = app_wrap;

endmodule : phase_accum

// ==== rtl/fund_energy_accum.sv ====
// Three-phase fundamental reactive-negative and apparent accumulators,
// per-phase overflow flag registers and the register read/write port.
// Assumes the serial interface decodes host frames into single-cycle
// read and write strobes with a 10-bit address, and the measurement
// pipeline gives one end-of-cycle strobe with all phase values valid.
// Timing
// Edge s, strobe high and enable high: every phase slice adds its
// apparent (or current) value and the magnitude of a negative reactive
// value, and registers both the new sums and a one-cycle wrap
// pulse taken from the carry out of the adder.
// Edge s+1: the wrap pulse is folded into the flag register of its
// phase, so a flag lags its accumulator by one clock. A host that
// polls the flags right after a strobe must allow for that clock.
// Read: request at edge r, answer valid for one clock after edge r,
// data held after that until the next accepted read.
// Write: only the flag addresses respond; a write can clear flag bits
// but never set them, and a wrap in the same clock keeps its bit set.
// Enable low: nothing moves, neither sums nor flags nor read data.
// Reset: synchronous and stronger than the enable.
//
// Limitations
// Cycle apparent values and currents are taken as unsigned magnitudes;
// a negative value from the pipeline would be added as a large number.
// Only the reactive-negative and apparent flag bits exist here; the
// other bits of each flag register read as zero.
`timescale 1ns/1ns
module fund_energy_accum
    import fund_accum_pkg::*;
#(
    parameter int PHASES = NUM_PHASES,
    parameter int W = ACC_W
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Measurement pipeline
    input wire logic i_cycle_strobe,
    input wire logic i_low_power,
    input wire logic [PHASES-1:0][W-1:0] i_cycle_react,
    input wire logic [PHASES-1:0][W-1:0] i_cycle_app,
    input wire logic [PHASES-1:0][W-1:0] i_cycle_current,
    // Host register port
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [FLAG_W-1:0] i_wr_data,
    output logic o_rd_valid,
    output logic [RD_W-1:0] o_rd_data
);

    // Refuse shapes the address map and read word cannot carry
    if (PHASES != NUM_PHASES) begin : g_bad_phases
        $error("fund_energy_accum: PHASES must equal NUM_PHASES");
    end
    if (W != RD_W) begin : g_bad_width
        $error("fund_energy_accum: W must equal the read word width");
    end

    // Bits of the flag register that this block owns
    localparam logic [FLAG_W-1:0] OWN_MASK =
        FLAG_W'((1 << RNEG_OVF_BIT) | (1 << APP_OVF_BIT));

    logic [FLAG_W-1:0] flags [PHASES];
    logic [FLAG_W-1:0] next_flags [PHASES];
    logic [W-1:0] rneg_acc [PHASES];
    logic [W-1:0] app_acc [PHASES];
    logic [PHASES-1:0] rneg_wrap;
    logic [PHASES-1:0] app_wrap;
    logic rd_valid;
    logic [RD_W-1:0] rd_data;
    logic next_rd_valid;
    logic [RD_W-1:0] next_rd_data;

    // One accumulator slice per phase, all on the shared strobe
    for (genvar p = 0; p < PHASES; p++) begin : g_phase
        accum_if #(.W(W)) link ();

        assign link.strobe = i_cycle_strobe;
        assign link.low_power = i_low_power;
        assign link.react = i_cycle_react[p];
        assign link.app = i_cycle_app[p];
        assign link.current = i_cycle_current[p];
        assign rneg_acc[p] = link.rneg_acc;
        assign app_acc[p] = link.app_acc;
        assign rneg_wrap[p] = link.rneg_wrap;
        assign app_wrap[p] = link.app_wrap;

        phase_accum #(
            .W(W)
        ) u_phase (
            .i_clk_sys(i_clk_sys),
            .i_rst_b(i_rst_b),
            .i_ce(i_ce),
            .bus(link.phase)
        );
    end

    // Write hit per phase, decoded apart from the flag update so the
    // clear term and the set terms stay readable side by side
    logic [PHASES-1:0] flag_wr_hit;

    // One compare per phase; flag addresses never overlap, so at most
    // one bit of the hit vector is high in any clock
    always_comb begin
        flag_wr_hit = '0;
        for (int p = 0; p < PHASES; p++) begin
            if (i_wr_en && (i_wr_addr == FLAG_ADDR[p])) begin
                flag_wr_hit[p] = 1'b1;
            end
        end
    end

    // Flags: host writes may only clear bits (write 0 clears); a wrap
    // in the same cycle is ORed in after the clear so the set wins.
    // Losing a wrap to a racing clear would hide a rollover from the
    // host, which would then under-count usage by a full range.
    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            next_flags[p] = flags[p];
            if (flag_wr_hit[p]) begin
                next_flags[p] = flags[p] & i_wr_data;
            end
            if (rneg_wrap[p]) begin
                next_flags[p][RNEG_OVF_BIT] = 1'b1;
            end
            if (app_wrap[p]) begin
                next_flags[p][APP_OVF_BIT] = 1'b1;
            end
            next_flags[p] = next_flags[p] & OWN_MASK;
        end
    end

    // Flag register stage
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            for (int p = 0; p < PHASES; p++) begin
                flags[p] <= FLAGS_RESET;
            end
        end else if (i_ce) begin
            for (int p = 0; p < PHASES; p++) begin
                flags[p] <= next_flags[p];
            end
        end
    end

    // Read decode; unmapped addresses answer zero but still respond.
    // Answering every read keeps the host's framing simple: it never
    // has to wait for a valid that might not come.
    always_comb begin
        next_rd_valid = i_rd_en;
        next_rd_data = RD_IDLE;
        if (i_rd_en) begin
            for (int p = 0; p < PHASES; p++) begin
                if (i_rd_addr == RNEG_ADDR[p]) begin
                    next_rd_data = rneg_acc[p];
                end else if (i_rd_addr == APP_ADDR[p]) begin
                    next_rd_data = app_acc[p];
                end else if (i_rd_addr == FLAG_ADDR[p]) begin
                    next_rd_data = {{(RD_W-FLAG_W){1'b0}}, flags[p]};
                end
            end
        end
    end

    // Read data held until the next read, valid for one cycle.
    // Sums are sampled at the read edge, so a strobe in the same edge
    // is not yet seen; the host reads again to get the new value.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rd_valid <= 1'b0;
            rd_data <= RD_IDLE;
        end else if (i_ce) begin
            rd_valid <= next_rd_valid;
            if (next_rd_valid) begin
                rd_data <= next_rd_data;
            end
        end
    end

    assign o_rd_valid = rd_valid;
    assign o_rd_data = rd_data;

endmodule : fund_energy_accum

// ==== tb/fund_energy_accum_checker.sv ====
// Checker for the accumulator block's host read/write port.
// Assumes it is bound to fund_energy_accum and sees its ports only.
`timescale 1ns/1ns
module fund_energy_accum_checker
    import fund_accum_pkg::*;
#(
    parameter int PHASES = NUM_PHASES,
    parameter int W = ACC_W
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Strobe and host port
    input wire logic i_cycle_strobe,
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [FLAG_W-1:0] i_wr_data,
    input wire logic o_rd_valid,
    input wire logic [RD_W-1:0] o_rd_data
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // Accepted read, what it hits, and edges with no accumulation
    wire logic rd = i_ce && i_rd_en;
    wire logic is_flag = i_rd_addr inside {FLAG_ADDR};
    wire logic is_acc = i_rd_addr inside {RNEG_ADDR, APP_ADDR};
    wire logic quiet = i_ce && !i_cycle_strobe;

    chk_read_answer: assert property (rd |=> o_rd_valid)
        else $error("read not answered");
    chk_valid_pulse: assert property (
        i_ce && !i_rd_en |=> !o_rd_valid) else $error("stray valid");
    chk_data_hold: assert property (
        i_ce && !i_rd_en |=> $stable(o_rd_data)) else $error("data moved");
    chk_ce_freeze: assert property (
        !i_ce |=> $stable(o_rd_valid) && $stable(o_rd_data))
        else $error("state moved while disabled");
    chk_unmapped_zero: assert property (
        rd && !is_flag && !is_acc |=> o_rd_data == '0)
        else $error("unmapped read not zero");
    chk_flag_bits: assert property (
        rd && is_flag |=> o_rd_data[31:5] == '0 && o_rd_data[2:0] == '0)
        else $error("flag read has stray bits");
    // Two reads of one sum with no strobe between must agree
    chk_accum_steady: assert property (
        rd && is_acc && quiet ##1 rd && quiet && $stable(i_rd_addr)
        |=> $stable(o_rd_data)) else $error("sum moved without strobe");
    chk_flag_clear: assert property (
        quiet ##1 quiet && i_wr_en && i_wr_data == '0 ##1
        rd && is_flag && quiet && i_rd_addr == $past(i_wr_addr)
        |=> o_rd_data == '0) else $error("flag not cleared");

    cov_flag_set: cover property (rd && is_flag ##1 o_rd_data[4:3] != '0);
    cov_flag_write: cover property (i_ce && i_wr_en);
    cov_strobe_read: cover property (i_cycle_strobe ##1 rd && is_acc);
endmodule : fund_energy_accum_checker

bind fund_energy_accum fund_energy_accum_checker #(.PHASES(PHASES),
    .W(W)) i_chk (.i_clk_sys, .i_rst_b, .i_ce, .i_cycle_strobe, .i_rd_en,
    .i_rd_addr, .i_wr_en, .i_wr_addr, .i_wr_data, .o_rd_valid, .o_rd_data);

// ==== tb/host_model.sv ====
// Host side of the register port: reads, flag writes, usage sums.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/1ns
module host_model
    import fund_accum_pkg::*;
(
    // Clock and answers
    input wire logic i_clk_sys,
    input wire logic i_rd_valid,
    input wire logic [RD_W-1:0] i_rd_data,
    // Requests
    output logic o_rd_en = 1'b0,
    output logic [ADDR_W-1:0] o_rd_addr = '0,
    output logic o_wr_en = 1'b0,
    output logic [ADDR_W-1:0] o_wr_addr = '0,
    output logic [FLAG_W-1:0] o_wr_data = '0
);
    // Back-to-back reads of one place; the second answer is kept
    task automatic rd(input logic [ADDR_W-1:0] a,
        output logic [RD_W-1:0] d, output logic ok);
        o_rd_en = 1'b1;
        o_rd_addr = a;
        @(negedge i_clk_sys);
        ok = i_rd_valid;
        @(negedge i_clk_sys);
        ok = ok & i_rd_valid;
        d = i_rd_data;
        o_rd_en = 1'b0;
        o_rd_addr = ~a; // Released address never shows the old value
        @(negedge i_clk_sys); // Idle clock so a next call never re-drives
    endtask : rd
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        o_wr_en = 1'b1;
        o_wr_addr = a;
        o_wr_data = v;
        @(negedge i_clk_sys);
        o_wr_en = 1'b0;
        o_wr_data = ~v;
    endtask : wr
    // A wrap is a rollover, so the full range joins the difference
    function automatic logic [32:0] usage(input logic [31:0] prev, cur,
        input logic wrapped);
        return {wrapped, cur} - {1'b0, prev};
    endfunction : usage
endmodule : host_model

// ==== tb/fund_energy_accum_bench.sv ====
// Bench for the fundamental energy accumulators.
// Assumes host_model speaks the register port for it.
`timescale 1ns/1ns
module fund_energy_accum_bench import fund_accum_pkg::*;;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic strobe = 1'b0;
    logic lp = 1'b0;
    logic [2:0][31:0] react = '0, app = '0, cur = '0;
    logic rd_en, wr_en, rd_valid;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [FLAG_W-1:0] wr_data;
    logic [RD_W-1:0] rd_data;
    int n_errors = 0;
    int compares = 0;
    always #25 clk = ~clk;
    fund_energy_accum i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_cycle_strobe(strobe), .i_low_power(lp), .i_cycle_react(react),
        .i_cycle_app(app), .i_cycle_current(cur), .i_rd_en(rd_en),
        .i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    host_model i_host (.i_clk_sys(clk), .i_rd_valid(rd_valid),
        .i_rd_data(rd_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr),
        .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    task automatic summarize;
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [RD_W-1:0] d;
        logic ok;
        i_host.rd(a, d, ok);
        compares++;
        if (ok !== 1'b1 || d !== e) begin
            n_errors++;
            $display("mismatch %0t addr %h got %h", $time, a, d);
        end
    endtask : check
    // One end-of-cycle strobe; index 0 is phase A
    task automatic pulse(input logic [2:0][31:0] r, a, c);
        react = r;
        app = a;
        cur = c;
        strobe = 1'b1;
        @(negedge clk);
        strobe = 1'b0;
    endtask : pulse
    // Tests take about 66 cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        pulse({32'h8000_0000, 32'h3, 32'hFFFF_FFFB},
            {32'h2, 32'h1, 32'h7}, '0);
        check(RNEG_ADDR[0], 32'h5);
        check(RNEG_ADDR[1], 32'h0);
        check(RNEG_ADDR[2], 32'h8000_0000);
        check(APP_ADDR[0], 32'h7);
        check(APP_ADDR[1], 32'h1);
        check(APP_ADDR[2], 32'h2);
        // Both sums wrap on one strobe
        pulse({32'h8000_0000, 64'h0}, {64'h0, 32'hFFFF_FFFA}, '0);
        check(RNEG_ADDR[2], 32'h0);
        check(APP_ADDR[0], 32'h1);
        check(FLAG_ADDR[2], 32'h8);
        check(FLAG_ADDR[0], 32'h10);
        check(FLAG_ADDR[1], 32'h0);
        compares++;
        if (i_host.usage(32'h8000_0000, 32'h0, 1'b1)
            !== 33'h0_8000_0000) begin
            n_errors++;
            $display("mismatch %0t usage", $time);
        end
        // Low power: current replaces apparent energy
        lp = 1'b1;
        pulse('0, {3{32'h100}}, {3{32'h10}});
        check(APP_ADDR[0], 32'h11);
        check(APP_ADDR[2], 32'h12);
        ce = 1'b0;
        pulse({3{32'hFFFF_FFFF}}, '0, {3{32'h10}});
        ce = 1'b1;
        check(RNEG_ADDR[0], 32'h5);
        check(FLAG_ADDR[2], 32'h8);
        i_host.wr(FLAG_ADDR[0], 8'h00);
        check(FLAG_ADDR[0], 32'h0);
        i_host.wr(FLAG_ADDR[1], 8'hFF);
        check(FLAG_ADDR[1], 32'h0);
        check(10'h000, 32'h0);
        summarize();
    end
endmodule : fund_energy_accum_bench
